// ==== src/vwm_voice_wake_ctrl.v ====
// top of the voice wake mode control block: serial target port,
// register file, boot sequencer and power manager
// assumes scl and sda arrive synchronous to sys_clk; the sda wire is
// open drain and resolved outside from sdaOut and sdaOeN
`timescale 1ns/10ps
`default_nettype none
`include "vwm_defs.vh"

module vwm_voice_wake_ctrl #(
	parameter KW_BITS = 5,
	parameter PARAM_AW = 4,
	parameter [7:0] BOOT_BYTES = `VWM_BOOT_BYTES
) (
	input wire sys_clk,
	input wire rst,
	input wire hwResetNIn,
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOeN,
	output wire voiceWakeIrqOut,
	output wire keywordWakeIrqOut,
	output wire otpRd,
	output wire [`VWM_OTP_AW-1:0] otpAddr,
	input wire [7:0] otpData,
	input wire otpValid,
	input wire voiceDetect,
	output wire voiceRun,
	output wire kwPower,
	input wire kwDone,
	input wire kwMatch,
	input wire [KW_BITS-1:0] kwIndex,
	output reg [2:0] gain,
	input wire [PARAM_AW-1:0] cfgSel,
	output reg [7:0] cfgData,
	output wire bootDone
);

	localparam [1:0] I_IDLE = 2'd0;
	localparam [1:0] I_RX = 2'd1;
	localparam [1:0] I_TX = 2'd2;
	// the parameter window is aligned to its own size, so one mask finds it
	localparam [15:0] PARAM_MASK = (16'h0001 << PARAM_AW) - 16'h0001;
	localparam PARAM_N = 1 << PARAM_AW;

	// true when an address falls in the classifier parameter window
	function paramHit;
		input [15:0] a;
		begin
			paramHit = (a & ~PARAM_MASK) == `VWM_REG_PARAM;
		end
	endfunction

	// --------------------------------------------------------------
	// hardware reset pin
	// --------------------------------------------------------------
	// the pin clears the logic synchronously so the async tree stays
	// driven by rst alone
	reg clr;

	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			clr <= 1'b1;
		else
			clr <= ~hwResetNIn;
	end

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	reg sclQ;
	reg sdaQ;
	reg [1:0] i2cSt;
	reg [3:0] bitCnt;
	reg [7:0] shifter;
	reg [1:0] byteNo;
	reg rnw;
	reg mAck;
	reg [15:0] regAddr;
	reg hostWr;
	reg [7:0] hostData;
	reg voiceAck;
	reg kwAck;
	reg [7:0] ctrl;
	reg [7:0] param [0:PARAM_N-1];
	reg [7:0] rdByte;
	integer i;

	wire bootWr;
	wire [7:0] bootIdx;
	wire [7:0] bootData;
	wire voiceIrq;
	wire kwIrq;
	wire kwValid;
	wire [KW_BITS-1:0] kwResult;

	// a burst wraps at the top of the 16-bit space rather than stopping
	wire [15:0] addrNext = regAddr + 16'h0001;
	wire sclRise = sclIn & ~sclQ;
	wire sclFall = ~sclIn & sclQ;
	wire startCond = sclIn & sclQ & sdaQ & ~sdaIn;
	wire stopCond = sclIn & sclQ & ~sdaQ & sdaIn;
	wire active = (i2cSt != I_IDLE) && !clr;
	wire ackFall = active && sclFall && (bitCnt == 4'd9);
	wire loadNow = ackFall && ((i2cSt == I_RX && byteNo == 2'd0 && rnw) || (i2cSt == I_TX && mAck));
	wire run = ctrl[`VWM_CTRL_RUN];
	wire [1:0] mode = ctrl[`VWM_CTRL_MODE_HI:`VWM_CTRL_MODE_LO];
	wire wrEn = hostWr | bootWr;
	wire [15:0] wrAddr = bootWr ? (`VWM_REG_CTRL + {8'h00, bootIdx}) : regAddr;
	wire [7:0] wrData = bootWr ? bootData : hostData;

	assign voiceWakeIrqOut = voiceIrq;
	assign keywordWakeIrqOut = kwIrq;

	// --------------------------------------------------------------
	// read multiplexer
	// --------------------------------------------------------------
	// reading the status or result register is what clears its wake flag,
	// so this mux and the ack pulses must agree on regAddr
	always @* begin
		rdByte = 8'h00;
		case (regAddr)
			`VWM_REG_CTRL: rdByte = ctrl;
			`VWM_REG_GAIN: rdByte = {5'h00, gain};
			`VWM_REG_VSTAT: rdByte = {5'h00, bootDone, kwPower, voiceIrq};
			`VWM_REG_KWRES: rdByte = {kwValid, {(7 - KW_BITS){1'b0}}, kwResult};
			default: begin
				if (paramHit(regAddr))
					rdByte = param[regAddr[PARAM_AW-1:0]];
			end
		endcase
	end

	// --------------------------------------------------------------
	// serial target engine
	// --------------------------------------------------------------
	// bitCnt counts scl rises in a byte: 1..8 data, 9 acknowledge.
	// sda is only ever pulled low, scl is never driven.
	// start and stop always release sda, so a host that aborts mid-byte
	// never finds the line held
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			i2cSt <= I_IDLE;
			bitCnt <= 4'h0;
			shifter <= 8'h00;
			byteNo <= 2'd0;
			rnw <= 1'b0;
			mAck <= 1'b0;
			regAddr <= 16'h0000;
			hostWr <= 1'b0;
			hostData <= 8'h00;
			voiceAck <= 1'b0;
			kwAck <= 1'b0;
			sdaOut <= 1'b0;
			sdaOeN <= 1'b1;
		end else begin
			sclQ <= sclIn;
			sdaQ <= sdaIn;
			sdaOut <= 1'b0;
			hostWr <= 1'b0;
			voiceAck <= loadNow && (regAddr == `VWM_REG_VSTAT);
			kwAck <= loadNow && (regAddr == `VWM_REG_KWRES);
			if (clr) begin
				i2cSt <= I_IDLE;
				bitCnt <= 4'h0;
				byteNo <= 2'd0;
				regAddr <= 16'h0000;
				sdaOeN <= 1'b1;
			end else if (startCond) begin
				// repeated start keeps regAddr for the read that follows
				i2cSt <= I_RX;
				bitCnt <= 4'h0;
				byteNo <= 2'd0;
				sdaOeN <= 1'b1;
			end else if (stopCond) begin
				i2cSt <= I_IDLE;
				sdaOeN <= 1'b1;
			end else if (active && sclRise) begin
				if (bitCnt != 4'd9)
					bitCnt <= bitCnt + 4'd1;
				if (i2cSt == I_RX && bitCnt < 4'd8)
					shifter <= {shifter[6:0], sdaIn};
				if (i2cSt == I_TX && bitCnt == 4'd8)
					mAck <= ~sdaIn;
			end else if (loadNow) begin
				bitCnt <= 4'h0;
				i2cSt <= I_TX;
				shifter <= rdByte;
				sdaOeN <= rdByte[7];
				regAddr <= addrNext;
			end else if (ackFall) begin
				bitCnt <= 4'h0;
				sdaOeN <= 1'b1;
				if (i2cSt == I_TX) begin
					// host gave no acknowledge: the burst read ends
					i2cSt <= I_IDLE;
				end else begin
					if (byteNo != 2'd3)
						byteNo <= byteNo + 2'd1;
					if (byteNo == 2'd3)
						regAddr <= addrNext;
				end
			end else if (active && sclFall) begin
				if (bitCnt == 4'd8 && i2cSt == I_RX) begin
					case (byteNo)
						2'd0: begin
							// ten-bit headers and other targets fall through here
							if (shifter[7:1] == `VWM_I2C_ADDR && bootDone) begin
								rnw <= shifter[0];
								sdaOeN <= 1'b0;
							end else begin
								i2cSt <= I_IDLE;
							end
						end
						2'd1: begin
							regAddr[15:8] <= shifter;
							sdaOeN <= 1'b0;
						end
						2'd2: begin
							regAddr[7:0] <= shifter;
							sdaOeN <= 1'b0;
						end
						default: begin
							hostWr <= 1'b1;
							hostData <= shifter;
							sdaOeN <= 1'b0;
						end
					endcase
				end else if (bitCnt == 4'd8) begin
					// release for the host's acknowledge
					sdaOeN <= 1'b1;
				end else if (i2cSt == I_TX && bitCnt != 4'd0) begin
					shifter <= {shifter[6:0], 1'b0};
					sdaOeN <= shifter[6];
				end
			end
		end
	end

	// --------------------------------------------------------------
	// register file
	// --------------------------------------------------------------
	// the classifiers read parameters through cfgSel one cycle late;
	// status and result registers are not writable
	// boot and host share one write port; the port refuses the host until
	// bootDone, so the two can never collide
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= `VWM_CTRL_RST;
			gain <= `VWM_GAIN_RST;
			cfgData <= 8'h00;
			for (i = 0; i < PARAM_N; i = i + 1)
				param[i] <= 8'h00;
		end else if (clr) begin
			ctrl <= `VWM_CTRL_RST;
			gain <= `VWM_GAIN_RST;
			cfgData <= 8'h00;
			for (i = 0; i < PARAM_N; i = i + 1)
				param[i] <= 8'h00;
		end else begin
			cfgData <= param[cfgSel];
			if (wrEn) begin
				case (wrAddr)
					`VWM_REG_CTRL: ctrl <= wrData;
					`VWM_REG_GAIN: gain <= wrData[2:0];
					default: begin
						if (paramHit(wrAddr))
							param[wrAddr[PARAM_AW-1:0]] <= wrData;
					end
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// boot and power management
	// --------------------------------------------------------------
	vwm_boot_loader #(
		.BOOT_BYTES(BOOT_BYTES)
	) uBoot (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(clr),
		.otpRd(otpRd),
		.otpAddr(otpAddr),
		.otpData(otpData),
		.otpValid(otpValid),
		.bootWr(bootWr),
		.bootIdx(bootIdx),
		.bootData(bootData),
		.bootDone(bootDone)
	);

	vwm_power_manager #(
		.KW_BITS(KW_BITS)
	) uPower (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(clr),
		.run(run),
		.mode(mode),
		.voiceDetect(voiceDetect),
		.kwDone(kwDone),
		.kwMatch(kwMatch),
		.kwIndex(kwIndex),
		.voiceAck(voiceAck),
		.kwAck(kwAck),
		.kwPower(kwPower),
		.voiceRun(voiceRun),
		.voiceIrq(voiceIrq),
		.kwIrq(kwIrq),
		.kwValid(kwValid),
		.kwResult(kwResult)
	);

endmodule // vwm_voice_wake_ctrl
`default_nettype wire

// ==== src/vwm_defs.vh ====
// constants shared by the voice wake mode control block
// assumes inclusion by bare name from every design file of the block
`ifndef VWM_DEFS_VH
`define VWM_DEFS_VH

// --------------------------------------------------------------
// serial target port
// --------------------------------------------------------------
`define VWM_I2C_ADDR 7'h5a

// --------------------------------------------------------------
// internal register addresses (16-bit, sent high byte first)
// --------------------------------------------------------------
`define VWM_REG_CTRL 16'h0000
`define VWM_REG_GAIN 16'h0001
`define VWM_REG_VSTAT 16'h0002
`define VWM_REG_KWRES 16'h0003
`define VWM_REG_PARAM 16'h0100

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define VWM_CTRL_RUN 0
`define VWM_CTRL_MODE_LO 1
`define VWM_CTRL_MODE_HI 2
`define VWM_CTRL_RST 8'h00
`define VWM_GAIN_RST 3'h0
`define VWM_MODE_VOICE 2'h0
`define VWM_MODE_KEYWORD 2'h1
`define VWM_MODE_COMBINED 2'h2

// --------------------------------------------------------------
// boot from one-time memory
// --------------------------------------------------------------
`define VWM_OTP_AW 15
`define VWM_OTP_BOOT_BASE 15'h0000
`define VWM_BOOT_BYTES 8'h02

`endif

// ==== src/vwm_boot_loader.v ====
// boot sequencer: copies the first bytes of one-time memory into
// the control registers after power-on or a hardware reset
// assumes the memory answers each held read with a one-cycle valid
`timescale 1ns/10ps
`default_nettype none
`include "vwm_defs.vh"

module vwm_boot_loader #(
	parameter [7:0] BOOT_BYTES = `VWM_BOOT_BYTES
) (
	input wire sys_clk,
	input wire rst,
	input wire clr,
	output reg otpRd,
	output wire [`VWM_OTP_AW-1:0] otpAddr,
	input wire [7:0] otpData,
	input wire otpValid,
	output reg bootWr,
	output reg [7:0] bootIdx,
	output reg [7:0] bootData,
	output reg bootDone
);

	localparam [7:0] LAST = BOOT_BYTES - 8'h01;

	assign otpAddr = `VWM_OTP_BOOT_BASE + {7'h00, bootIdx};

	// --------------------------------------------------------------
	// fetch, store, advance
	// --------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			otpRd <= 1'b0;
			bootWr <= 1'b0;
			bootIdx <= 8'h00;
			bootData <= 8'h00;
			bootDone <= 1'b0;
		end else if (clr) begin
			otpRd <= 1'b0;
			bootWr <= 1'b0;
			bootIdx <= 8'h00;
			bootData <= 8'h00;
			bootDone <= 1'b0;
		end else begin
			bootWr <= 1'b0;
			if (!bootDone) begin
				if (otpRd && otpValid) begin
					otpRd <= 1'b0;
					bootWr <= 1'b1;
					bootData <= otpData;
				end else if (bootWr) begin
					if (bootIdx == LAST)
						bootDone <= 1'b1;
					else
						bootIdx <= bootIdx + 8'h01;
				end else if (!otpRd) begin
					otpRd <= 1'b1;
				end
			end
		end
	end

endmodule // vwm_boot_loader
`default_nettype wire

// ==== src/vwm_power_manager.v ====
// power manager and mode sequencer for the two classifiers,
// with the two sticky wake interrupts
// assumes detection and done inputs are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "vwm_defs.vh"

module vwm_power_manager #(
	parameter KW_BITS = 5
) (
	input wire sys_clk,
	input wire rst,
	input wire clr,
	input wire run,
	input wire [1:0] mode,
	input wire voiceDetect,
	input wire kwDone,
	input wire kwMatch,
	input wire [KW_BITS-1:0] kwIndex,
	input wire voiceAck,
	input wire kwAck,
	output reg kwPower,
	output reg voiceRun,
	output reg voiceIrq,
	output reg kwIrq,
	output reg kwValid,
	output reg [KW_BITS-1:0] kwResult
);

	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_LISTEN = 2'd1;
	localparam [1:0] S_KW = 2'd2;

	reg [1:0] st;
	reg [1:0] next_st;

	wire kwHit = (st == S_KW) && kwDone && kwMatch;
	wire voiceHit = (st == S_LISTEN) && voiceDetect && (mode != `VWM_MODE_COMBINED);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always @* begin
		next_st = st;
		case (st)
			S_IDLE: begin
				if (run)
					next_st = (mode == `VWM_MODE_KEYWORD) ? S_KW : S_LISTEN;
			end
			S_LISTEN: begin
				if (!run)
					next_st = S_IDLE;
				else if (mode == `VWM_MODE_KEYWORD)
					next_st = S_KW;
				else if (voiceDetect && mode == `VWM_MODE_COMBINED)
					next_st = S_KW;
			end
			S_KW: begin
				if (!run)
					next_st = S_IDLE;
				else if (mode != `VWM_MODE_KEYWORD && (kwDone || mode != `VWM_MODE_COMBINED))
					next_st = S_LISTEN;
			end
			default: next_st = S_IDLE;
		endcase
	end

	// --------------------------------------------------------------
	// state, power and interrupts; a new event beats a same-cycle read
	// --------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st <= S_IDLE;
			kwPower <= 1'b0;
			voiceRun <= 1'b0;
			voiceIrq <= 1'b0;
			kwIrq <= 1'b0;
			kwValid <= 1'b0;
			kwResult <= {KW_BITS{1'b0}};
		end else if (clr) begin
			st <= S_IDLE;
			kwPower <= 1'b0;
			voiceRun <= 1'b0;
			voiceIrq <= 1'b0;
			kwIrq <= 1'b0;
			kwValid <= 1'b0;
			kwResult <= {KW_BITS{1'b0}};
		end else begin
			st <= next_st;
			kwPower <= (next_st == S_KW);
			voiceRun <= run && (mode != `VWM_MODE_KEYWORD);
			if (voiceHit)
				voiceIrq <= 1'b1;
			else if (voiceAck)
				voiceIrq <= 1'b0;
			if (kwHit) begin
				kwIrq <= 1'b1;
				kwValid <= 1'b1;
				kwResult <= kwIndex;
			end else if (kwAck) begin
				kwIrq <= 1'b0;
				kwValid <= 1'b0;
			end
		end
	end

endmodule // vwm_power_manager
`default_nettype wire

// ==== tb/vwmc_checker.sv ====
// concurrent checks on the voice wake block, seeing only its top-level ports
// assumes serial bus inputs arrive synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module vwmc_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hwResetNIn,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	input wire logic voiceWakeIrqOut,
	input wire logic keywordWakeIrqOut,
	input wire logic otpRd,
	input wire logic otpValid,
	input wire logic voiceDetect,
	input wire logic voiceRun,
	input wire logic kwPower,
	input wire logic kwDone,
	input wire logic kwMatch,
	input wire logic bootDone
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// sequences and properties
	// ------------------------------------------------------------
	sequence s_rstHold;
		!hwResetNIn ##1 !hwResetNIn;
	endsequence
	sequence s_kwHit;
		kwDone && kwMatch && kwPower;
	endsequence
	property p_tgtScl;
		$changed(sdaOeN) |-> !sclIn && !sdaOut;
	endproperty
	property p_noEarlyAck;
		!bootDone |-> sdaOeN;
	endproperty
	property p_vIrq;
		$rose(voiceWakeIrqOut) |-> $past(voiceDetect && voiceRun);
	endproperty
	property p_kwIrq;
		s_kwHit |=> keywordWakeIrqOut;
	endproperty
	property p_kwCause;
		$rose(keywordWakeIrqOut) |-> $past(kwDone && kwMatch && kwPower);
	endproperty
	property p_kwOn;
		$rose(kwPower) && voiceRun |-> $past(voiceDetect);
	endproperty
	property p_kwOff;
		kwDone && kwPower && voiceRun |=> !kwPower;
	endproperty
	// a wake flag may only drop after a status or result read or a hardware reset
	property p_vSticky;
		$fell(voiceWakeIrqOut) |-> $past(!sclIn, 2) || !$past(hwResetNIn, 2);
	endproperty
	property p_kSticky;
		$fell(keywordWakeIrqOut) |-> $past(!sclIn, 2) || !$past(hwResetNIn, 2);
	endproperty
	property p_hwRst;
		s_rstHold |=> !bootDone && !kwPower && !otpRd && !voiceWakeIrqOut && !keywordWakeIrqOut;
	endproperty
	property p_otpHold;
		otpRd && !otpValid && hwResetNIn |=> otpRd;
	endproperty
	a_tgtScl: assert property (p_tgtScl) else $error("data line moved while clock high");
	a_noEarlyAck: assert property (p_noEarlyAck) else $error("acknowledge before boot");
	a_vIrq: assert property (p_vIrq) else $error("voice wake without detection");
	a_kwIrq: assert property (p_kwIrq) else $error("keyword match gave no wake");
	a_kwCause: assert property (p_kwCause) else $error("keyword wake without match");
	a_kwOn: assert property (p_kwOn) else $error("keyword unit woke without detection");
	a_kwOff: assert property (p_kwOff) else $error("keyword unit not put to sleep");
	a_vSticky: assert property (p_vSticky) else $error("voice wake dropped early");
	a_kSticky: assert property (p_kSticky) else $error("keyword wake dropped early");
	a_hwRst: assert property (p_hwRst) else $error("hardware reset did not clear");
	a_otpHold: assert property (p_otpHold) else $error("memory read dropped early");
endmodule // vwmc_checker

bind vwm_voice_wake_ctrl vwmc_checker u_chk (.sys_clk(sys_clk), .rst(rst), .hwResetNIn(hwResetNIn),
	.sclIn(sclIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .voiceWakeIrqOut(voiceWakeIrqOut),
	.keywordWakeIrqOut(keywordWakeIrqOut), .otpRd(otpRd), .otpValid(otpValid), .voiceDetect(voiceDetect),
	.voiceRun(voiceRun), .kwPower(kwPower), .kwDone(kwDone), .kwMatch(kwMatch), .bootDone(bootDone));
`default_nettype wire

// ==== tb/vwmc_host_model.sv ====
// host serial master model driving the clock and pulling the data wire
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
module vwmc_host_model #(
	parameter int HALF = 64,
	parameter logic [6:0] DEV = 7'h5a
) (
	input wire logic sys_clk,
	input wire logic sdaLine,
	output logic sclIn,
	output logic hostSdaLow,
	output logic [7:0] rdData,
	output logic rdStrobe
);
	localparam int Q = HALF / 2;
	logic ackOk;
	initial begin
		sclIn = 1'b1;
		hostSdaLow = 1'b0;
		rdData = 8'h00;
		rdStrobe = 1'b0;
		ackOk = 1'b0;
	end
	// ------------------------------------------------------------
	// bit and frame tasks
	// ------------------------------------------------------------
	// 64 cycles a half period keeps the bit rate below 400 kHz
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic bitx(input logic o, output logic i);
		w(Q);
		hostSdaLow = !o;
		w(Q);
		sclIn = 1'b1;
		w(Q);
		i = sdaLine;
		w(Q);
		sclIn = 1'b0;
	endtask
	task automatic start();
		if (!sclIn) begin
			w(Q);
			hostSdaLow = 1'b0;
			w(Q);
			sclIn = 1'b1;
			w(HALF);
		end
		hostSdaLow = 1'b1;
		w(HALF);
		sclIn = 1'b0;
	endtask
	task automatic stop();
		w(Q);
		hostSdaLow = 1'b1;
		w(Q);
		sclIn = 1'b1;
		w(HALF);
		hostSdaLow = 1'b0;
		w(HALF);
	endtask
	task automatic sendb(input logic [7:0] b);
		logic a;
		for (int k = 7; k >= 0; k--) bitx(b[k], a);
		bitx(1'b1, a);
		ackOk = ackOk && !a;
	endtask
	task automatic head(input logic [6:0] dev, input logic [15:0] addr);
		ackOk = 1'b1;
		start();
		sendb({dev, 1'b0});
		sendb(addr[15:8]);
		sendb(addr[7:0]);
	endtask
	task automatic write(input logic [6:0] dev, input logic [15:0] addr, input logic [15:0] data, input int n,
		output logic ok);
		head(dev, addr);
		for (int k = 0; k < n; k++) sendb(data[15 - 8 * k -: 8]);
		stop();
		ok = ackOk;
	endtask
	task automatic read(input logic [15:0] addr, input int n);
		logic [7:0] d;
		logic x;
		head(DEV, addr);
		start();
		sendb({DEV, 1'b1});
		for (int k = 0; k < n; k++) begin
			for (int j = 7; j >= 0; j--) bitx(1'b1, d[j]);
			bitx(k == n - 1, x);
			rdData = d;
			rdStrobe = 1'b1;
			w(1);
			rdStrobe = 1'b0;
		end
		stop();
	endtask
endmodule // vwmc_host_model
`default_nettype wire

// ==== tb/voice_wake_mode_control_test.sv ====
// self-checking bench: boot, the three modes, wake flags, serial access
// assumes the design header is on the include path
`timescale 1ns/10ps
`default_nettype none
module voice_wake_mode_control_test;
	localparam logic [7:0] BOOT_CTRL = 8'h01;
	logic sysClk = 1'b0, rst = 1'b1, hwResetNIn = 1'b1, otpValid = 1'b0, voiceDetect = 1'b0;
	logic kwDone = 1'b0, kwMatch = 1'b0, otpStall = 1'b0, ok;
	logic sclIn, hostSdaLow, rdStrobe, sdaLine, sdaOut, sdaOeN, voiceIrq, kwIrq, otpRd, voiceRun, kwPower;
	logic bootDone;
	logic [14:0] otpAddr;
	logic [7:0] otpData = 8'h00, cfgData, rdData;
	logic [7:0] expQ[$];
	logic [4:0] kwIndex = 5'h00, idx;
	logic [2:0] gain, bootGain, newGain;
	logic [3:0] cfgSel = 4'h0;
	logic [15:0] params;
	int fails = 0, nTests = 0, seed = 38;
	assign sdaLine = !(hostSdaLow || !sdaOeN);
	always #10 sysClk = ~sysClk;
	vwm_voice_wake_ctrl u_dut (.sys_clk(sysClk), .rst(rst), .hwResetNIn(hwResetNIn), .sclIn(sclIn),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .voiceWakeIrqOut(voiceIrq), .keywordWakeIrqOut(kwIrq),
		.otpRd(otpRd), .otpAddr(otpAddr), .otpData(otpData), .otpValid(otpValid), .voiceDetect(voiceDetect),
		.voiceRun(voiceRun), .kwPower(kwPower), .kwDone(kwDone), .kwMatch(kwMatch), .kwIndex(kwIndex),
		.gain(gain), .cfgSel(cfgSel), .cfgData(cfgData), .bootDone(bootDone));
	vwmc_host_model u_host (.sys_clk(sysClk), .sdaLine(sdaLine), .sclIn(sclIn), .hostSdaLow(hostSdaLow),
		.rdData(rdData), .rdStrobe(rdStrobe));
	// ------------------------------------------------------------
	// memory model, compare and helper tasks
	// ------------------------------------------------------------
	always @(posedge sysClk) begin
		#1;
		otpValid = otpRd && !otpValid && !otpStall;
		otpData = (otpAddr == 15'h0000) ? BOOT_CTRL : {5'h00, bootGain};
	end
	always @(posedge sysClk) if (rdStrobe === 1'b1) check_byte(expQ.size() ? expQ.pop_front() : 8'hxx, rdData);
	task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic check_bit(input logic exp, input logic got);
		check_byte({7'h00, exp}, {7'h00, got});
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask
	task automatic wait_boot();
		for (int k = 0; k < 40 && bootDone !== 1'b1; k++) tick(1);
	endtask
	task automatic voice_pulse();
		voiceDetect = 1'b1;
		tick(1);
		voiceDetect = 1'b0;
		tick(1);
	endtask
	// index is scrambled after the strobe, so a result not latched on it shows
	task automatic kw_pulse(input logic m, input logic [4:0] i);
		kwMatch = m;
		kwIndex = i;
		kwDone = 1'b1;
		tick(1);
		kwDone = 1'b0;
		kwMatch = !m;
		kwIndex = ~i;
		tick(1);
	endtask
	// about twice the expected run
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		bootGain = 3'($random(seed));
		tick(3);
		rst = 1'b0;
		wait_boot();
		check_bit(1'b1, bootDone);
		check_byte({5'h00, bootGain}, {5'h00, gain});
		check_bit(1'b1, voiceRun);
		check_bit(1'b0, kwPower);
		u_host.write(7'h5b, 16'h0000, 16'h0700, 1, ok);
		check_bit(1'b0, ok);
		u_host.write(7'h78, 16'h0000, 16'h0700, 1, ok);
		check_bit(1'b0, ok);
		voice_pulse();
		check_bit(1'b1, voiceIrq);
		check_bit(1'b0, kwIrq);
		expQ.push_back(8'h05);
		expQ.push_back(8'h00);
		u_host.read(16'h0002, 2);
		tick(4);
		check_bit(1'b0, voiceIrq);
		newGain = 3'($random(seed));
		u_host.write(7'h5a, 16'h0000, {8'h05, 5'h00, newGain}, 2, ok);
		check_bit(1'b1, ok);
		check_byte({5'h00, newGain}, {5'h00, gain});
		voice_pulse();
		check_bit(1'b1, kwPower);
		check_bit(1'b0, voiceIrq);
		idx = 5'($unsigned($random(seed)) % 30);
		kw_pulse(1'b1, idx);
		check_bit(1'b1, kwIrq);
		check_bit(1'b0, kwPower);
		expQ.push_back({3'h4, idx});
		u_host.read(16'h0003, 1);
		tick(4);
		check_bit(1'b0, kwIrq);
		u_host.write(7'h5a, 16'h0000, 16'h0300, 1, ok);
		check_bit(1'b0, voiceRun);
		for (int m = 0; m < 2; m++) begin
			kw_pulse(m[0], 5'h1d);
			check_bit(m[0], kwIrq);
			check_bit(1'b1, kwPower);
		end
		u_host.write(7'h5a, 16'h0000, 16'h0700, 1, ok);
		check_bit(1'b1, voiceRun);
		voice_pulse();
		check_bit(1'b1, voiceIrq);
		params = 16'($random(seed));
		u_host.write(7'h5a, 16'h0100, params, 2, ok);
		for (int k = 0; k < 2; k++) begin
			cfgSel = 4'(k);
			tick(2);
			check_byte(params[15 - 8 * k -: 8], cfgData);
		end
		hwResetNIn = 1'b0;
		tick(3);
		check_bit(1'b0, bootDone);
		check_bit(1'b0, kwIrq);
		check_bit(1'b0, voiceIrq);
		otpStall = 1'b1;
		hwResetNIn = 1'b1;
		tick(2);
		u_host.write(7'h5a, 16'h0001, 16'h0500, 1, ok);
		check_bit(1'b0, ok);
		check_bit(1'b0, bootDone);
		otpStall = 1'b0;
		wait_boot();
		check_byte({5'h00, bootGain}, {5'h00, gain});
		report_and_stop();
	end
endmodule // voice_wake_mode_control_test
`default_nettype wire
